//--- include/sia_if.sv
// Shared serial interrupt line joining the device agent and the host controller
`timescale 1ns/1ps
`default_nettype none
interface sia_if;
    logic dev_o;
    logic dev_oe;
    logic host_o;
    logic host_oe;
    logic line;

    // Any driver pulling low wins; a released line floats high through the pull-up
    assign line = ((dev_oe & ~dev_o) | (host_oe & ~host_o)) ? 1'b0 : 1'b1;

    modport dev (
        input  line,
        output dev_o,
        output dev_oe
    );

    modport host (
        input  line,
        output host_o,
        output host_oe
    );
endinterface : sia_if
`default_nettype wire

//--- include/sia_pkg.sv
// Shared constants, state types and frame decode for the serial interrupt link
package sia_pkg;

    // Frame layout, counted in clocks after the start pulse's rising edge
    localparam logic [5:0] FIRST_CNT     = 6'h01;
    localparam logic [6:0] FRAME_CLKS    = 7'h03;
    localparam logic [4:0] FIRST_PERIOD  = 5'h02;
    localparam logic [4:0] LAST_PERIOD   = 5'h10;
    // Turn-around clock of period 16 (3*16+1) and of period 17 (3*17+1)
    localparam logic [5:0] DEV_LAST_CNT  = 6'h31;
    localparam logic [5:0] HOST_LAST_CNT = 6'h34;

    // Phases within a frame
    localparam logic [1:0] PH_SAMPLE     = 2'h0;
    localparam logic [1:0] PH_RECOVERY   = 2'h1;

    // Pulse widths in clocks
    localparam logic [3:0] START_MIN_CLKS = 4'h4;
    localparam logic [3:0] START_MAX_CLKS = 4'h8;
    localparam logic [3:0] STOP_QUIET_CLKS = 4'h2;
    localparam logic [3:0] STOP_CONT_CLKS  = 4'h3;

    // Position of the management-interrupt frame enable in enable register 2
    localparam int unsigned SMI_FRAME_EN_BIT = 6;

    // Reset values: continuous mode, every interrupt level high
    localparam logic        MODE_RESET_QUIET = 1'b0;
    localparam logic [15:1] LVL_RESET        = 15'h7FFF;

    typedef enum logic [4:0] {
        DS_IDLE      = 5'h01,
        DS_START     = 5'h02,
        DS_WAIT_RISE = 5'h04,
        DS_FRAMES    = 5'h08,
        DS_STOP      = 5'h10
    } sia_dev_state_t;

    typedef enum logic [5:0] {
        HS_IDLE     = 6'h01,
        HS_START    = 6'h02,
        HS_START_HI = 6'h04,
        HS_FRAMES   = 6'h08,
        HS_STOP     = 6'h10,
        HS_STOP_HI  = 6'h20
    } sia_host_state_t;

    function automatic logic [4:0] frame_period(input logic [5:0] cnt);
        logic [6:0] t;
        t = {1'b0, cnt} + 7'h01;
        return 5'(t / FRAME_CLKS);
    endfunction : frame_period

    function automatic logic [1:0] frame_phase(input logic [5:0] cnt);
        logic [6:0] t;
        t = {1'b0, cnt} + 7'h01;
        return 2'(t % FRAME_CLKS);
    endfunction : frame_phase

endpackage : sia_pkg

//--- testbench/serial_irq_slave_agent_tb.sv
// Testbench joining device and host over the shared serial interrupt line
`timescale 1ns/1ps
`default_nettype none
module serial_irq_slave_agent_tb;
    localparam int LIMIT = 10000;
    logic        clk_i;
    logic        srst_i;
    logic [15:1] irq;
    logic        smi_n;
    logic        smi_en;
    logic        start_req;
    logic        quiet_req;
    logic [3:0]  width;
    logic [15:1] lvl;
    logic        done;
    logic        h_quiet;
    logic        h_act;
    logic        d_quiet;
    logic        d_act;
    int          n_errors = 0;
    int          cmp_count = 0;
    int          cyc = 0;
    int          k;
    int          i;

    sia_if link_if ();
    sia_device u_sia_device (.clk_i(clk_i), .srst_i(srst_i), .link(link_if.dev), .irq_i(irq),
        .system_mgmt_irq_n_i(smi_n), .smi_frame_en_i(smi_en), .quiet_mode_o(d_quiet), .cycle_active_o(d_act));
    sia_host u_sia_host (.clk_i(clk_i), .srst_i(srst_i), .link(link_if.host), .start_req_i(start_req),
        .quiet_req_i(quiet_req), .start_width_i(width), .irq_level_o(lvl), .cycle_done_o(done),
        .quiet_mode_o(h_quiet), .cycle_active_o(h_act));
    sia_checker u_chk (.clk_i(clk_i), .srst_i(srst_i), .dev_o(link_if.dev_o), .dev_oe(link_if.dev_oe),
        .host_o(link_if.host_o), .host_oe(link_if.host_oe), .line(link_if.line));

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    function automatic logic [15:0] exp_lvl(input logic [15:1] v, input logic s, input logic e);
        logic [15:1] r;
        r = v;
        r[2] = v[2] & (s | ~e);
        return {r, 1'b0};
    endfunction : exp_lvl

    task automatic end_sim();
        $display("Comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_sim

    // Wait for the end of a cycle, then compare what the host collected
    task automatic finish_cycle();
        for (k = 0; k < 100 && done !== 1'b1; k++) @(negedge clk_i);
        check("cycle_done", {15'h0, done}, 16'h0001);
        check("levels", {lvl, 1'b0}, exp_lvl(irq, smi_n, smi_en));
        check("modes", {14'h0, h_quiet, d_quiet}, {14'h0, quiet_req, quiet_req});
    endtask : finish_cycle

    task automatic run_cycle(input logic host_go);
        logic prev_q;
        prev_q = quiet_req;
        @(negedge clk_i);
        irq = 15'($urandom);
        irq[1] = ~lvl[1];
        smi_n = 1'($urandom);
        smi_en = 1'($urandom);
        // Full range so the clamp to four and eight low clocks is reached
        width = 4'($urandom);
        quiet_req = 1'($urandom);
        if (!prev_q) begin
            repeat (80) @(negedge clk_i);
            check("passive_continuous", {14'h0, h_act, d_act}, 16'h0000);
        end
        start_req = host_go | ~prev_q;
        for (k = 0; k < 12 && h_act !== 1'b1; k++) @(negedge clk_i);
        // The device sees a host-begun start one edge after the host enters it
        @(negedge clk_i);
        check("cycle_started", {14'h0, h_act, d_act}, 16'h0003);
        start_req = 1'b0;
        finish_cycle();
    endtask : run_cycle

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    // Hang guard
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == LIMIT) begin
            n_errors++;
            end_sim();
        end
    end

    initial begin
        void'($urandom(11));
        srst_i = 1'b1;
        irq = 15'($urandom);
        irq[2] = 1'b1;
        // Management interrupt low but not enabled: period 3 must stay high
        smi_n = 1'b0;
        smi_en = 1'b0;
        start_req = 1'b0;
        quiet_req = 1'b0;
        width = 4'h8;
        repeat (12) @(negedge clk_i);
        check("reset_line", {15'h0, link_if.line}, 16'h0001);
        check("reset_state", {lvl, h_quiet}, {15'h7FFF, 1'b0});
        check("reset_mode", {15'h0, d_quiet}, 16'h0000);
        srst_i = 1'b0;
        finish_cycle();
        for (i = 0; i < 20; i++) run_cycle(1'($urandom));
        // Reset in mid-cycle: line released, defaults back, host restarts alone
        start_req = 1'b1;
        repeat (20) @(negedge clk_i);
        srst_i = 1'b1;
        start_req = 1'b0;
        repeat (3) @(negedge clk_i);
        check("midrst_line", {15'h0, link_if.line}, 16'h0001);
        check("midrst_state", {lvl, h_quiet}, {15'h7FFF, 1'b0});
        check("midrst_mode", {14'h0, h_act, d_quiet}, 16'h0000);
        srst_i = 1'b0;
        finish_cycle();
        end_sim();
    end
endmodule : serial_irq_slave_agent_tb
`default_nettype wire

//--- testbench/sia_checker.sv
// Line-level checker for the shared serial interrupt link
`timescale 1ns/1ps
`default_nettype none
module sia_checker (
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // Line drivers and resolved level
    input wire logic dev_o,
    input wire logic dev_oe,
    input wire logic host_o,
    input wire logic host_oe,
    input wire logic line
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);

    logic [3:0] hlow_reg;
    logic [3:0] llow_reg;
    logic [5:0] frm_reg;
    wire        dev_lo  = dev_oe & ~dev_o;
    wire        dev_hi  = dev_oe & dev_o;
    wire        host_lo = host_oe & ~host_o;

    // Frame count restarts only after a low run long enough to be a start
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            hlow_reg <= 4'h0;
            llow_reg <= 4'h0;
            frm_reg  <= 6'h00;
        end else begin
            hlow_reg <= host_lo ? hlow_reg + ((hlow_reg == 4'hF) ? 4'h0 : 4'h1) : 4'h0;
            llow_reg <= !line ? llow_reg + ((llow_reg == 4'hF) ? 4'h0 : 4'h1) : 4'h0;
            if (host_oe && host_o && llow_reg >= 4'h4)
                frm_reg <= 6'h01;
            else if (frm_reg != 6'h00 && frm_reg < 6'h34)
                frm_reg <= frm_reg + 6'h01;
            else
                frm_reg <= 6'h00;
        end
    end

    property p_rst_rel;
        $fell(srst_i) |-> !dev_oe && !host_oe;
    endproperty
    a_rst_rel: assert property (p_rst_rel) else $error("line driven after reset");
    property p_no_fight;
        dev_lo |-> !host_oe;
    endproperty
    a_no_fight: assert property (p_no_fight) else $error("device low while host drives");
    property p_lo_once;
        dev_lo |=> !dev_lo;
    endproperty
    a_lo_once: assert property (p_lo_once) else $error("device low longer than one clock");
    property p_hi_after_lo;
        dev_hi |-> $past(dev_lo);
    endproperty
    a_hi_after_lo: assert property (p_hi_after_lo) else $error("device high without low before");
    property p_turn_rel;
        dev_hi |=> !dev_oe;
    endproperty
    a_turn_rel: assert property (p_turn_rel) else $error("device drives in turn-around");
    property p_slot;
        dev_lo && frm_reg != 6'h00 |-> frm_reg % 6'h03 == 6'h02 && frm_reg >= 6'h05 && frm_reg <= 6'h2F;
    endproperty
    a_slot: assert property (p_slot) else $error("device low outside a sample clock");
    property p_start_idle;
        dev_lo && frm_reg == 6'h00 |-> $past(line);
    endproperty
    a_start_idle: assert property (p_start_idle) else $error("device start on busy line");
    property p_host_width;
        $fell(host_lo) |-> hlow_reg >= 4'h2 && hlow_reg <= 4'h8;
    endproperty
    a_host_width: assert property (p_host_width) else $error("host low width out of range");
    property p_host_high;
        $fell(host_lo) |-> host_oe && host_o ##1 !host_oe;
    endproperty
    a_host_high: assert property (p_host_high) else $error("host high clock missing");
    property p_start_width;
        $rose(line) && llow_reg >= 4'h4 |-> llow_reg <= 4'h8;
    endproperty
    a_start_width: assert property (p_start_width) else $error("start low width out of range");
endmodule : sia_checker
`default_nettype wire

//--- verilog/sia_device.sv
// Serial interrupt device agent: reports interrupt levels in its frames
`timescale 1ns/1ps
`default_nettype none

module sia_device
    import sia_pkg::*;
(
    // Clock and reset (the bus reset drive)
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    // Shared line
    sia_if.dev               link,
    // Interrupt sources, levels for interrupts 1 to 15
    input  wire logic [15:1] irq_i,
    input  wire logic        system_mgmt_irq_n_i,
    // Management-interrupt frame enable, bit 6 of enable register 2
    input  wire logic        smi_frame_en_i,
    // Status
    output logic             quiet_mode_o,
    output logic             cycle_active_o
);

    sia_dev_state_t state_reg, state_next;
    logic [5:0]  cnt_reg, cnt_next;
    logic [3:0]  low_reg, low_next;
    logic        quiet_reg, quiet_next;
    logic        hold_reg, hold_next;
    logic        drove_reg;
    logic [15:1] lvl_reg;
    logic [15:1] sent_reg;

    // Sources and change tracking

    wire         line_low = ~link.line;

    // Period 3 merges interrupt 2 with the management interrupt;
    // software keeps only one of them in use
    wire         smi_lvl  = system_mgmt_irq_n_i | ~smi_frame_en_i;
    wire  [15:1] src_lvl  = {irq_i[15:3], irq_i[2] & smi_lvl, irq_i[1]};

    // A change made after its slot was sampled in this cycle stays pending,
    // so in quiet mode it triggers a fresh start once the line is idle again
    wire         pending  = |(lvl_reg ^ sent_reg);

    // Frame position decode

    wire  [4:0]  period   = frame_period(cnt_reg);
    wire  [1:0]  phase    = frame_phase(cnt_reg);
    wire  [3:0]  idx      = period[3:0] - 4'h1;
    wire         owned    = (state_reg == DS_FRAMES)
                            && period >= FIRST_PERIOD
                            && period <= LAST_PERIOD;
    wire         in_sample   = owned && (phase == PH_SAMPLE);
    wire         in_recovery = owned && (phase == PH_RECOVERY);
    wire         slot_lvl    = lvl_reg[idx];

    // Line drive

    wire         start_low = (state_reg == DS_START);
    wire         data_low  = in_sample && !slot_lvl;
    wire         data_high = in_recovery && drove_reg;
    wire         start_ok  = quiet_reg && !hold_reg && pending;

    // Turn-around and every other clock fall through to released
    assign link.dev_oe = start_low | data_low | data_high;
    assign link.dev_o  = data_high;

    // Sequencing

    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        low_next   = low_reg;
        quiet_next = quiet_reg;
        hold_next  = 1'b0;
        case (state_reg)
            DS_IDLE: begin
                if (line_low) begin
                    // Another agent or the host has begun a cycle
                    state_next = DS_WAIT_RISE;
                end else if (start_ok) begin
                    state_next = DS_START;
                end
            end
            DS_START: begin
                // Exactly one low clock; the host carries the pulse on
                state_next = DS_WAIT_RISE;
            end
            DS_WAIT_RISE: begin
                if (!line_low) begin
                    state_next = DS_FRAMES;
                    cnt_next   = FIRST_CNT;
                end
            end
            DS_FRAMES: begin
                cnt_next = cnt_reg + 6'h01;
                if (cnt_reg == DEV_LAST_CNT) begin
                    state_next = DS_STOP;
                    low_next   = 4'h0;
                end
            end
            DS_STOP: begin
                // Single low clocks are other agents' samples, not a stop
                if (line_low) begin
                    if (low_reg != 4'hF) begin
                        low_next = low_reg + 4'h1;
                    end
                end else if (low_reg == STOP_QUIET_CLKS) begin
                    state_next = DS_IDLE;
                    quiet_next = 1'b1;
                    hold_next  = 1'b1;
                end else if (low_reg == STOP_CONT_CLKS) begin
                    state_next = DS_IDLE;
                    quiet_next = 1'b0;
                    hold_next  = 1'b1;
                end else begin
                    low_next = 4'h0;
                end
            end
            default: begin
                state_next = DS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state_reg <= DS_IDLE;
            cnt_reg   <= 6'h00;
            low_reg   <= 4'h0;
            quiet_reg <= MODE_RESET_QUIET;
            hold_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            low_reg   <= low_next;
            quiet_reg <= quiet_next;
            hold_reg  <= hold_next;
        end
    end

    // Level capture and delivery record

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            lvl_reg <= LVL_RESET;
        end else begin
            lvl_reg <= src_lvl;
        end
    end

    // The host holds the reset defaults, so nothing counts as pending
    // until a level differs from them
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            sent_reg <= LVL_RESET;
        end else if (in_sample) begin
            sent_reg[idx] <= slot_lvl;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            drove_reg <= 1'b0;
        end else if (owned) begin
            drove_reg <= data_low;
        end else begin
            drove_reg <= 1'b0;
        end
    end

    // Status

    assign quiet_mode_o   = quiet_reg;
    assign cycle_active_o = (state_reg != DS_IDLE);

endmodule : sia_device
`default_nettype wire

//--- verilog/sia_host.sv
// Host serial interrupt controller: starts, times and stops cycles
`timescale 1ns/1ps
`default_nettype none
module sia_host
    import sia_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    // Shared line
    sia_if.host              link,
    // Control
    input  wire logic        start_req_i,
    input  wire logic        quiet_req_i,
    input  wire logic [3:0]  start_width_i,
    // Status
    output logic      [15:1] irq_level_o,
    output logic             cycle_done_o,
    output logic             quiet_mode_o,
    output logic             cycle_active_o
);

    sia_host_state_t state_reg, state_next;
    logic [5:0]  cnt_reg, cnt_next;
    logic [3:0]  low_reg, low_next;
    logic        quiet_reg, quiet_next;
    logic        stopq_reg, stopq_next;
    logic        first_reg, first_next;
    logic        done_reg, done_next;
    logic [15:1] lvl_reg;

    wire         line_low = ~link.line;
    wire  [4:0]  period   = frame_period(cnt_reg);
    wire  [3:0]  idx      = period[3:0] - 4'h1;
    wire         in_frame = (state_reg == HS_FRAMES);
    wire         sample   = in_frame && frame_phase(cnt_reg) == PH_SAMPLE
                            && period >= FIRST_PERIOD && period <= LAST_PERIOD;
    wire  [3:0]  width    = (start_width_i < START_MIN_CLKS) ? START_MIN_CLKS :
                            (start_width_i > START_MAX_CLKS) ? START_MAX_CLKS : start_width_i;

    assign link.host_oe = (state_reg == HS_START) || (state_reg == HS_START_HI)
                        || (state_reg == HS_STOP) || (state_reg == HS_STOP_HI);
    assign link.host_o  = (state_reg == HS_START_HI) || (state_reg == HS_STOP_HI);

    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        low_next   = low_reg;
        quiet_next = quiet_reg;
        stopq_next = stopq_reg;
        first_next = first_reg;
        done_next  = 1'b0;
        case (state_reg)
            HS_IDLE: begin
                if (quiet_reg && line_low) begin
                    // A slave's one-clock start counts toward the total width
                    state_next = HS_START;
                    low_next   = width - 4'h1;
                end else if (first_reg || start_req_i) begin
                    state_next = HS_START;
                    low_next   = width;
                    first_next = 1'b0;
                end
            end
            HS_START: begin
                low_next = low_reg - 4'h1;
                if (low_reg == 4'h1) begin
                    state_next = HS_START_HI;
                end
            end
            HS_START_HI: begin
                state_next = HS_FRAMES;
                cnt_next   = FIRST_CNT;
            end
            HS_FRAMES: begin
                cnt_next = cnt_reg + 6'h01;
                if (cnt_reg == HOST_LAST_CNT) begin
                    state_next = HS_STOP;
                    low_next   = quiet_req_i ? STOP_QUIET_CLKS : STOP_CONT_CLKS;
                    stopq_next = quiet_req_i;
                end
            end
            HS_STOP: begin
                low_next = low_reg - 4'h1;
                if (low_reg == 4'h1) begin
                    state_next = HS_STOP_HI;
                    quiet_next = stopq_reg;
                end
            end
            HS_STOP_HI: begin
                state_next = HS_IDLE;
                done_next  = 1'b1;
            end
            default: begin
                state_next = HS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state_reg <= HS_IDLE;
            cnt_reg   <= 6'h00;
            low_reg   <= 4'h0;
            quiet_reg <= MODE_RESET_QUIET;
            stopq_reg <= MODE_RESET_QUIET;
            first_reg <= 1'b1;
            done_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            low_reg   <= low_next;
            quiet_reg <= quiet_next;
            stopq_reg <= stopq_next;
            first_reg <= first_next;
            done_reg  <= done_next;
        end
    end

    // Defaults stand until the first cycle has sampled real levels
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            lvl_reg <= LVL_RESET;
        end else if (sample) begin
            lvl_reg[idx] <= link.line;
        end
    end

    assign irq_level_o    = lvl_reg;
    assign cycle_done_o   = done_reg;
    assign quiet_mode_o   = quiet_reg;
    assign cycle_active_o = (state_reg != HS_IDLE);

endmodule : sia_host
`default_nettype wire
